/* rsts_regs.vh */
`ifndef RSTS_REGS_VH
`define RSTS_REGS_VH
// register byte offsets
`define RSTS_OFS_STATUS      4'h0
`define RSTS_OFS_CTRL        4'h4
`define RSTS_OFS_TRAP        4'h8
// control fields and reset value
`define RSTS_CTRL_RUN_BIT    0
`define RSTS_CTRL_QUERY_BIT  1
`define RSTS_CTRL_RST        1'b1
// status fields
`define RSTS_ST_WARN_LSB     0
`define RSTS_ST_FAIL_LSB     8
`define RSTS_ST_PROT_BIT     16
`define RSTS_ST_ALARM_BIT    17
`define RSTS_ST_HALT_BIT     18
// timing
`define RSTS_CLK_KHZ         20000
`define RSTS_TICK_MS         200
`define RSTS_RAM_MS          60000
`define RSTS_PULSE_MS        5000
`define RSTS_OSC_MS          1
// limits, millivolts and degrees C
`define RSTS_CHAN_OFS_MV     16'd30
`define RSTS_CONV_WARN_MV    16'd20
`define RSTS_CONV_FAIL_MV    16'd30
`define RSTS_REG_WARN_LO     16'd4650
`define RSTS_REG_WARN_HI     16'd5350
`define RSTS_REG_FAIL_LO     16'd4500
`define RSTS_REG_FAIL_HI     16'd5500
`define RSTS_BAT_WARN_LO     16'd2250
`define RSTS_BAT_WARN_HI     16'd5000
`define RSTS_BAT_FAIL_LO     16'd2100
`define RSTS_BAT_FAIL_HI     16'd6000
`define RSTS_TMP_WARN_LO     -8'sd40
`define RSTS_TMP_WARN_HI     8'sd85
`define RSTS_TMP_FAIL_LO     -8'sd50
`define RSTS_TMP_FAIL_HI     8'sd100
`define RSTS_MAIN_LO         16'd4650
`define RSTS_MAIN_HI         16'd5950
// display message codes
`define RSTS_MSG_NONE        4'h0
`define RSTS_MSG_SELFTEST    4'h1
`define RSTS_MSG_OSC_LOST    4'h2
`define RSTS_MSG_TRAP        4'h3
// serial flow control and query characters
`define RSTS_CHR_XON         8'h11
`define RSTS_CHR_XOFF        8'h13
`define RSTS_CHR_QUERY       8'h53
`endif

/* rsts_supervisor.v */
`timescale 1ns/1ps
`include "rsts_regs.vh"
module rsts_supervisor #(
	parameter [31:0] TICK_CYC  = `RSTS_TICK_MS * `RSTS_CLK_KHZ,
	parameter [31:0] RAM_CYC   = `RSTS_RAM_MS * `RSTS_CLK_KHZ,
	parameter [31:0] PULSE_CYC = `RSTS_PULSE_MS * `RSTS_CLK_KHZ,
	parameter [31:0] OSC_CYC   = `RSTS_OSC_MS * `RSTS_CLK_KHZ
) (
	input  wire        ref_clk,
	input  wire        srst,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [95:0] chan_offset_mv,
	input  wire [15:0] conv_offset_mv,
	input  wire [15:0] reg_pos_mv,
	input  wire [15:0] reg_neg_mv,
	input  wire [15:0] battery_mv,
	input  wire [7:0]  temp_c,
	input  wire [15:0] main_rail_mv,
	input  wire        program_sum_ok,
	input  wire        working_settings_copy_ok,
	input  wire        stored_settings_ok,
	input  wire        osc_beat,
	input  wire        trap_stb,
	input  wire [7:0]  trap_num,
	output wire        ram_req,
	output wire        ram_we,
	output reg  [3:0]  ram_addr,
	output reg  [15:0] ram_wdata,
	input  wire [15:0] ram_rdata,
	input  wire        rx_valid,
	input  wire [7:0]  rx_byte,
	input  wire        status_button,
	output reg         report_stb,
	output reg  [15:0] report_word,
	output reg         tx_hold,
	output reg         disp_stb,
	output reg  [3:0]  disp_code,
	output reg  [7:0]  disp_arg,
	output reg         prot_enable,
	output reg         contacts_enable,
	output reg         en_lamp,
	output reg         alarm_coil,
	output reg         cpu_halt,
	output reg         cpu_reset
);
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_WR   = 4'b0010;
	localparam [3:0] S_RD   = 4'b0100;
	localparam [3:0] S_CMP  = 4'b1000;

	reg  [31:0] tick_cnt_q;
	reg  [31:0] ram_cnt_q;
	reg  [31:0] pulse_cnt_q;
	reg  [31:0] osc_cnt_q;
	reg         tick_q;
	reg         ram_go_q;
	reg         run_q;
	reg         ack_q;
	reg  [7:0]  warn_q;
	reg  [7:0]  warn_prev_q;
	reg  [7:0]  fail_q;
	reg         hw_fail_q;
	reg  [7:0]  trap_q;
	reg         ram_bad_q;
	reg         pend_q;
	reg  [3:0]  st_q;
	reg  [3:0]  st_d;
	wire [5:0]  chan_hi;
	wire [7:0]  warn_now;
	wire [7:0]  fail_now;
	wire [7:0]  warn_new;
	wire [7:0]  fail_new;
	wire        rail_ok;
	wire        osc_dead;
	wire        query;
	wire        wr_ok;
	wire        rd_ok;
	wire        sel_ctrl;
	wire        temp_warn;
	wire        temp_fail;
	wire        ram_mis;
	wire        pulsed_ev;
	wire        latch_any;

	// per-channel offset comparators
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_chan
			assign chan_hi[gi] = chan_offset_mv[16*gi +: 16] > `RSTS_CHAN_OFS_MV;
		end
	endgenerate

	function [15:0] pat;
		input [3:0] a;
		begin
			pat = {a, ~a, a, ~a};
		end
	endfunction

	assign temp_warn = ($signed(temp_c) < `RSTS_TMP_WARN_LO) || ($signed(temp_c) > `RSTS_TMP_WARN_HI);
	assign temp_fail = ($signed(temp_c) < `RSTS_TMP_FAIL_LO) || ($signed(temp_c) > `RSTS_TMP_FAIL_HI);

	// warnings: 0 chan ofs, 1 conv ofs, 2 reg rail, 3 battery warn, 4 battery fail, 5 temp
	assign warn_now[0] = |chan_hi;
	assign warn_now[1] = conv_offset_mv > `RSTS_CONV_WARN_MV;
	assign warn_now[2] = (reg_pos_mv < `RSTS_REG_WARN_LO) || (reg_pos_mv > `RSTS_REG_WARN_HI) ||
		(reg_neg_mv < `RSTS_REG_WARN_LO) || (reg_neg_mv > `RSTS_REG_WARN_HI);
	assign warn_now[3] = (battery_mv < `RSTS_BAT_WARN_LO) || (battery_mv > `RSTS_BAT_WARN_HI);
	assign warn_now[4] = (battery_mv < `RSTS_BAT_FAIL_LO) || (battery_mv > `RSTS_BAT_FAIL_HI);
	assign warn_now[5] = temp_warn;
	assign warn_now[7:6] = 2'b00;

	// failures: 0 conv ofs, 1 reg rail, 2 temp, 3 ram, 4 program, 5 working, 6 stored
	assign fail_now[0] = conv_offset_mv > `RSTS_CONV_FAIL_MV;
	assign fail_now[1] = (reg_pos_mv < `RSTS_REG_FAIL_LO) || (reg_pos_mv > `RSTS_REG_FAIL_HI) ||
		(reg_neg_mv < `RSTS_REG_FAIL_LO) || (reg_neg_mv > `RSTS_REG_FAIL_HI);
	assign fail_now[2] = temp_fail;
	assign fail_now[3] = ram_bad_q;
	assign fail_now[4] = ~program_sum_ok;
	assign fail_now[5] = ~working_settings_copy_ok;
	assign fail_now[6] = ~stored_settings_ok;
	assign fail_now[7] = 1'b0;

	// periodic tests take effect only on the 0.2 s tick
	assign warn_new = (tick_q && run_q) ? (warn_now & ~warn_prev_q) : 8'h00;
	assign fail_new = (tick_q && run_q) ? (fail_now & ~fail_q) : 8'h00;
	// pulsed alarm from warnings 0 to 4, including both battery outcomes, not from temp
	assign pulsed_ev = |(warn_new & 8'h1f);
	assign latch_any = (|fail_q) || hw_fail_q;

	assign rail_ok  = (main_rail_mv >= `RSTS_MAIN_LO) && (main_rail_mv <= `RSTS_MAIN_HI);
	assign osc_dead = (osc_cnt_q >= OSC_CYC);
	assign ram_mis  = st_q[3] && (ram_rdata != pat(ram_addr));
	assign query    = status_button || (rx_valid && rx_byte == `RSTS_CHR_QUERY) ||
		(wr_ok && sel_ctrl && avs_byteenable[0] && avs_writedata[`RSTS_CTRL_QUERY_BIT]);

	// avalon slave: one wait cycle, answer at the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_ok    = avs_write && ack_q;
	assign rd_ok    = avs_read && !ack_q;
	assign sel_ctrl = avs_address[3:2] == `RSTS_OFS_CTRL >> 2;
	assign ram_req  = st_q[1] || st_q[2];
	assign ram_we   = st_q[1];

	always @(posedge ref_clk) begin
		if (srst) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			run_q        <= `RSTS_CTRL_RST;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
			if (wr_ok && sel_ctrl && avs_byteenable[0])
				run_q <= avs_writedata[`RSTS_CTRL_RUN_BIT];
			if (rd_ok) begin
				case (avs_address[3:2])
				`RSTS_OFS_STATUS >> 2: avs_readdata <= {13'h0000, cpu_halt, ~alarm_coil,
					prot_enable, fail_q, warn_q};
				`RSTS_OFS_CTRL >> 2: avs_readdata <= {31'h0000_0000, run_q};
				`RSTS_OFS_TRAP >> 2: avs_readdata <= {24'h00_0000, trap_q};
				default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// dividers for the periodic tests, oscillator watchdog
	always @(posedge ref_clk) begin
		if (srst) begin
			tick_cnt_q <= 32'h0000_0000;
			ram_cnt_q  <= 32'h0000_0000;
			osc_cnt_q  <= 32'h0000_0000;
			tick_q     <= 1'b0;
			ram_go_q   <= 1'b0;
		end else begin
			tick_q   <= tick_cnt_q == TICK_CYC - 32'h1;
			ram_go_q <= ram_cnt_q == RAM_CYC - 32'h1;
			tick_cnt_q <= (tick_cnt_q == TICK_CYC - 32'h1) ? 32'h0000_0000 : tick_cnt_q + 32'h1;
			ram_cnt_q  <= (ram_cnt_q == RAM_CYC - 32'h1) ? 32'h0000_0000 : ram_cnt_q + 32'h1;
			if (osc_beat)
				osc_cnt_q <= 32'h0000_0000;
			else if (!osc_dead)
				osc_cnt_q <= osc_cnt_q + 32'h1;
		end
	end

	// ram write/read-back walk over sixteen words
	always @* begin
		st_d = st_q;
		case (st_q)
		S_IDLE: if (ram_go_q && run_q) st_d = S_WR;
		S_WR: if (ram_addr == 4'hf) st_d = S_RD;
		S_RD: st_d = S_CMP;
		S_CMP: st_d = (ram_addr == 4'hf) ? S_IDLE : S_RD;
		default: st_d = S_IDLE;
		endcase
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			st_q      <= S_IDLE;
			ram_addr  <= 4'h0;
			ram_wdata <= 16'h0000;
			ram_bad_q <= 1'b0;
		end else begin
			st_q <= st_d;
			case (st_q)
			S_IDLE: begin
				ram_addr  <= 4'h0;
				ram_wdata <= pat(4'h0);
			end
			S_WR: begin
				ram_addr  <= ram_addr + 4'h1;
				ram_wdata <= pat(ram_addr + 4'h1);
			end
			S_CMP: ram_addr <= ram_addr + 4'h1;
			default: ram_addr <= ram_addr;
			endcase
			if (ram_mis)
				ram_bad_q <= 1'b1;
		end
	end

	// self-test state, alarm and protection outputs
	always @(posedge ref_clk) begin
		if (srst) begin
			warn_q          <= 8'h00;
			warn_prev_q     <= 8'h00;
			fail_q          <= 8'h00;
			hw_fail_q       <= 1'b0;
			trap_q          <= 8'h00;
			pulse_cnt_q     <= 32'h0000_0000;
			prot_enable     <= 1'b1;
			contacts_enable <= 1'b1;
			en_lamp         <= 1'b1;
			alarm_coil      <= 1'b1;
			cpu_halt        <= 1'b0;
			cpu_reset       <= 1'b0;
			disp_stb        <= 1'b0;
			disp_code       <= `RSTS_MSG_NONE;
			disp_arg        <= 8'h00;
		end else begin
			disp_stb <= 1'b0;
			if (tick_q && run_q) begin
				warn_q      <= warn_now;
				warn_prev_q <= warn_now;
			end
			fail_q <= fail_q | fail_new;
			if (|fail_new) begin
				disp_stb  <= 1'b1;
				disp_code <= `RSTS_MSG_SELFTEST;
			end
			if (osc_dead && !hw_fail_q) begin
				hw_fail_q <= 1'b1;
				cpu_halt  <= 1'b1;
				disp_stb  <= 1'b1;
				disp_code <= `RSTS_MSG_OSC_LOST;
			end else if (trap_stb && !hw_fail_q) begin
				hw_fail_q <= 1'b1;
				cpu_halt  <= 1'b1;
				trap_q    <= trap_num;
				disp_stb  <= 1'b1;
				disp_code <= `RSTS_MSG_TRAP;
				disp_arg  <= trap_num;
			end
			if (!rail_ok) begin
				hw_fail_q <= 1'b1;
				cpu_reset <= 1'b1;
				cpu_halt  <= 1'b1;
			end
			if (pulsed_ev)
				pulse_cnt_q <= PULSE_CYC;
			else if (pulse_cnt_q != 32'h0000_0000)
				pulse_cnt_q <= pulse_cnt_q - 32'h1;
			prot_enable     <= !(latch_any || (|fail_new));
			contacts_enable <= !(latch_any || (|fail_new));
			en_lamp         <= !(latch_any || (|fail_new));
			alarm_coil      <= !(latch_any || (|fail_new) || pulsed_ev ||
				(pulse_cnt_q > 32'h1));
		end
	end

	// serial status report with xon/xoff flow control
	always @(posedge ref_clk) begin
		if (srst) begin
			tx_hold     <= 1'b0;
			pend_q      <= 1'b0;
			report_stb  <= 1'b0;
			report_word <= 16'h0000;
		end else begin
			if (rx_valid && rx_byte == `RSTS_CHR_XOFF)
				tx_hold <= 1'b1;
			else if (rx_valid && rx_byte == `RSTS_CHR_XON)
				tx_hold <= 1'b0;
			report_stb <= 1'b0;
			if ((|warn_new) || (|fail_new) || query)
				pend_q <= 1'b1;
			else if (report_stb)
				pend_q <= 1'b0;
			if (pend_q && !tx_hold && !report_stb && !(rx_valid && rx_byte == `RSTS_CHR_XOFF)) begin
				report_stb  <= 1'b1;
				report_word <= {fail_q, warn_q};
			end
		end
	end
endmodule

/* rsts_props.sv */
`timescale 1ns/1ps
`include "rsts_regs.vh"
module rsts_props #(
	parameter [31:0] PULSE_CYC = 50
) (
	input wire        ref_clk,
	input wire        srst,
	input wire        avs_read,
	input wire        avs_write,
	input wire        avs_waitrequest,
	input wire        rx_valid,
	input wire [7:0]  rx_byte,
	input wire        trap_stb,
	input wire [15:0] main_rail_mv,
	input wire        report_stb,
	input wire        tx_hold,
	input wire        prot_enable,
	input wire        contacts_enable,
	input wire        en_lamp,
	input wire        alarm_coil,
	input wire        cpu_halt,
	input wire        cpu_reset
);
	reg [31:0] low_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// alarm cycles while protection stays on
	always @(posedge ref_clk) begin
		if (srst || alarm_coil || !prot_enable)
			low_q <= 32'h0;
		else
			low_q <= low_q + 32'h1;
	end
	bus_wait_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
		else $error("access answered without wait");
	contact_off_a: assert property (!prot_enable |-> !contacts_enable)
		else $error("contacts on with protection off");
	lamp_state_a: assert property (en_lamp == prot_enable)
		else $error("lamp differs from protection");
	alarm_fail_a: assert property (!prot_enable |-> !alarm_coil)
		else $error("no alarm with protection off");
	pulse_len_a: assert property (low_q <= PULSE_CYC + 32'd2)
		else $error("pulsed alarm too long");
	prot_latch_a: assert property (!prot_enable |=> !prot_enable)
		else $error("protection came back");
	halt_prot_a: assert property ($rose(cpu_halt) |-> ##[0:2] !prot_enable)
		else $error("halt left protection on");
	halt_latch_a: assert property (cpu_halt |=> cpu_halt)
		else $error("halt released");
	xoff_hold_a: assert property (rx_valid && rx_byte == `RSTS_CHR_XOFF |=> tx_hold)
		else $error("stop byte ignored");
	xon_free_a: assert property (rx_valid && rx_byte == `RSTS_CHR_XON |=> !tx_hold)
		else $error("resume byte ignored");
	quiet_tx_a: assert property (tx_hold |-> !report_stb)
		else $error("report sent while stopped");
	trap_halt_a: assert property (trap_stb |-> ##[1:2] cpu_halt)
		else $error("trap did not halt");
	rail_reset_a: assert property (main_rail_mv < `RSTS_MAIN_LO || main_rail_mv > `RSTS_MAIN_HI |-> ##[1:2] cpu_reset)
		else $error("rail fault without reset");
endmodule
bind rsts_supervisor rsts_props #(.PULSE_CYC(PULSE_CYC)) u_props (.ref_clk, .srst, .avs_read, .avs_write,
	.avs_waitrequest, .rx_valid, .rx_byte, .trap_stb, .main_rail_mv, .report_stb, .tx_hold, .prot_enable,
	.contacts_enable, .en_lamp, .alarm_coil, .cpu_halt, .cpu_reset);

/* rsts_ram_model.sv */
`timescale 1ns/1ps
module rsts_ram_model (
	input wire        ref_clk,
	input wire        ram_req,
	input wire        ram_we,
	input wire [3:0]  ram_addr,
	input wire [15:0] ram_wdata,
	input wire        corrupt,
	output reg [15:0] ram_rdata
);
	reg [15:0] mem [0:15];
	initial ram_rdata = 16'h0;
	// read data stands one cycle, then is scrambled
	always @(posedge ref_clk) begin
		if (ram_req && ram_we)
			mem[ram_addr] <= ram_wdata;
		if (ram_req && !ram_we)
			ram_rdata <= mem[ram_addr] ^ {15'h0, corrupt};
		else
			ram_rdata <= ~ram_rdata;
	end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`include "rsts_regs.vh"
`define CK(s,e,v) begin checked=checked+1; if ((e)!==(v)) begin errors=errors+1; $display("wrong value %s exp %0h got %0h",s,e,v); end end
module testbench;
	reg         ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, osc_on = 1'b1, osc_beat = 1'b0;
	reg         trap_stb = 1'b0, rx_valid = 1'b0, status_button = 1'b0, bad = 1'b0, program_sum_ok = 1'b1;
	reg         working_settings_copy_ok = 1'b1, stored_settings_ok = 1'b1;
	reg  [3:0]  avs_address = 4'h0, dc = 4'h0;
	reg  [31:0] avs_writedata = 32'h0, q;
	reg  [95:0] chan_offset_mv = 96'h0;
	reg  [15:0] conv_offset_mv = 16'h0, reg_pos_mv = 16'd5000, reg_neg_mv = 16'd5000, rw = 16'h0;
	reg  [15:0] battery_mv = 16'd3000, main_rail_mv = 16'd5000;
	reg  [7:0]  temp_c = 8'd25, trap_num = 8'h0, rx_byte = 8'h0, da = 8'h0;
	reg  [1:0]  bc = 2'h0;
	wire [31:0] avs_readdata;
	wire [15:0] ram_wdata, ram_rdata, report_word;
	wire [7:0]  disp_arg;
	wire [3:0]  ram_addr, disp_code;
	wire        avs_waitrequest, ram_req, ram_we, report_stb, tx_hold, disp_stb, prot_enable;
	wire        contacts_enable, en_lamp, alarm_coil, cpu_halt, cpu_reset;
	integer     errors = 0, checked = 0, n_rep = 0, n_disp = 0, lo = 0, n, m, i;
	rsts_supervisor #(.TICK_CYC(20), .RAM_CYC(200), .PULSE_CYC(50), .OSC_CYC(10)) dut (.ref_clk, .srst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
		.avs_waitrequest, .chan_offset_mv, .conv_offset_mv, .reg_pos_mv, .reg_neg_mv, .battery_mv, .temp_c,
		.main_rail_mv, .program_sum_ok, .working_settings_copy_ok, .stored_settings_ok, .osc_beat, .trap_stb,
		.trap_num, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .rx_valid, .rx_byte, .status_button,
		.report_stb, .report_word, .tx_hold, .disp_stb, .disp_code, .disp_arg, .prot_enable, .contacts_enable,
		.en_lamp, .alarm_coil, .cpu_halt, .cpu_reset);
	rsts_ram_model u_ram (.ref_clk, .ram_req, .ram_we, .ram_addr, .ram_wdata, .corrupt(bad), .ram_rdata);
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		bc <= bc + 2'h1;
		osc_beat <= osc_on && bc == 2'h0;
		if (report_stb === 1'b1) begin
			n_rep <= n_rep + 1;
			rw <= report_word;
		end
		if (disp_stb === 1'b1) begin
			n_disp <= n_disp + 1;
			dc <= disp_code;
			da <= disp_arg;
		end
		if (alarm_coil === 1'b0)
			lo <= lo + 1;
	end
	task close_out;
		begin
			$display("checked %0d errors %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task tick(input integer c);
		repeat (c) @(posedge ref_clk);
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge ref_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_read <= !w;
			avs_write <= w;
			k = 0;
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0 && k < 20) begin
				@(posedge ref_clk);
				k = k + 1;
			end
			if (k == 20) begin
				errors = errors + 1;
				close_out;
			end
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task send_rx(input [7:0] b);
		begin
			@(posedge ref_clk);
			rx_valid <= 1'b1;
			rx_byte <= b;
			@(posedge ref_clk);
			rx_valid <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rep_inc(input [15:0] w);
		begin
			tick(6);
			`CK("report count", n + 1, n_rep)
			`CK("report word", w, rw)
			n = n_rep;
		end
	endtask
	task do_rst;
		begin
			srst <= 1'b1;
			osc_on <= 1'b1;
			main_rail_mv <= 16'd5000;
			{chan_offset_mv, conv_offset_mv, battery_mv} <= {96'h0, 16'h0, 16'd3000};
			{reg_pos_mv, reg_neg_mv, temp_c} <= {16'd5000, 16'd5000, 8'h19};
			{program_sum_ok, working_settings_copy_ok, stored_settings_ok, bad} <= 4'he;
			tick(16);
			srst <= 1'b0;
			tick(1);
		end
	endtask
	task t_regs;
		begin
			bus(0, `RSTS_OFS_STATUS, 0);
			`CK("status", 32'h00010000, q)
			bus(0, `RSTS_OFS_CTRL, 0);
			`CK("ctrl", 32'h1, q)
			bus(1, 4'hc, 32'hffffffff);
			bus(0, 4'hc, 0);
			`CK("unmapped", 32'h0, q)
			bus(1, `RSTS_OFS_CTRL, 32'h0);
			bus(0, `RSTS_OFS_CTRL, 0);
			`CK("ctrl off", 32'h0, q)
			n = n_rep;
			bus(1, `RSTS_OFS_CTRL, 32'h3);
			rep_inc(16'h0);
			status_button <= 1'b1;
			tick(1);
			status_button <= 1'b0;
			rep_inc(16'h0);
		end
	endtask
	task t_warn;
		begin
			n = n_rep;
			m = n_disp;
			chan_offset_mv[95:80] <= 16'd30;
			tick(45);
			`CK("offset at limit", n, n_rep)
			chan_offset_mv[95:80] <= 16'd31;
			i = lo;
			tick(45);
			`CK("warn report", n + 1, n_rep)
			`CK("warn word", 16'h0001, rw)
			`CK("warn display", m, n_disp)
			`CK("warn protection", 1'b1, prot_enable)
			tick(60);
			`CK("pulse length", 1'b1, lo - i >= 48 && lo - i <= 52)
			`CK("pulse ended", 1'b1, alarm_coil)
			chan_offset_mv <= 96'h0;
		end
	endtask
	task t_xoff;
		begin
			send_rx(`RSTS_CHR_XOFF);
			`CK("stopped", 1'b1, tx_hold)
			n = n_rep;
			battery_mv <= 16'd2200;
			tick(50);
			`CK("held report", n, n_rep)
			`CK("battery protection", 1'b1, prot_enable)
			send_rx(`RSTS_CHR_XON);
			`CK("resumed", 1'b0, tx_hold)
			rep_inc(16'h0008);
			send_rx(`RSTS_CHR_QUERY);
			rep_inc(16'h0008);
		end
	endtask
	task t_fail;
		begin
			m = n_disp;
			conv_offset_mv <= 16'd40;
			tick(45);
			`CK("fail display", m + 1, n_disp)
			`CK("fail code", `RSTS_MSG_SELFTEST, dc)
			`CK("fail word", 8'h01, rw[15:8])
			`CK("protection", 1'b0, prot_enable)
			`CK("contacts", 1'b0, contacts_enable)
			`CK("lamp", 1'b0, en_lamp)
			`CK("alarm", 1'b0, alarm_coil)
			conv_offset_mv <= 16'h0;
			tick(120);
			`CK("latched", 2'b00, {alarm_coil, prot_enable})
			bus(0, `RSTS_OFS_STATUS, 0);
			`CK("status flags", 2'b10, q[17:16])
		end
	endtask
	task t_sums;
		begin
			program_sum_ok <= 1'b0;
			tick(45);
			`CK("program sum", 8'h10, rw[15:8])
			working_settings_copy_ok <= 1'b0;
			tick(45);
			`CK("working sum", 8'h30, rw[15:8])
			stored_settings_ok <= 1'b0;
			tick(45);
			`CK("stored sum", 8'h70, rw[15:8])
			bad <= 1'b1;
			tick(300);
			`CK("ram test", 8'h78, rw[15:8])
		end
	endtask
	task t_rails;
		begin
			reg_pos_mv <= 16'd4600;
			temp_c <= 8'hd3;
			battery_mv <= 16'd2000;
			tick(45);
			`CK("rail warn word", 16'h003c, rw)
			`CK("temp warn bit", 1'b1, rw[5])
			`CK("battery fail protection", 1'b1, prot_enable)
			`CK("rail pulse", 1'b0, alarm_coil)
			reg_neg_mv <= 16'd4400;
			temp_c <= 8'h6e;
			tick(45);
			`CK("rail fail word", 8'h06, rw[15:8])
			`CK("temp fail protection", 1'b0, prot_enable)
		end
	endtask
	task t_hw;
		begin
			n = n_rep;
			osc_on <= 1'b0;
			tick(30);
			`CK("osc halt", 1'b1, cpu_halt)
			`CK("osc message", `RSTS_MSG_OSC_LOST, dc)
			`CK("osc protection", 1'b0, prot_enable)
			`CK("osc unreported", n, n_rep)
			do_rst;
			trap_num <= 8'h2a;
			trap_stb <= 1'b1;
			tick(1);
			trap_stb <= 1'b0;
			tick(5);
			`CK("trap message", {`RSTS_MSG_TRAP, 8'h2a}, {dc, da})
			`CK("trap halt", 2'b10, {cpu_halt, prot_enable})
			main_rail_mv <= 16'd4000;
			tick(4);
			`CK("rail reset", 1'b1, cpu_reset)
		end
	endtask
	initial begin
		do_rst;
		t_regs;
		t_warn;
		t_xoff;
		do_rst;
		t_fail;
		do_rst;
		t_sums;
		do_rst;
		t_rails;
		do_rst;
		t_hw;
		close_out;
	end
endmodule
